// ---- verilog/ide_channel.sv ----
// One independent disk interface channel engine
`include "ide_host_params.svh"
`default_nettype none
module ide_channel
  import ide_host_pkg::*;
#(
  parameter int SETUP_CYC = `SETUP_CYC,
  parameter int STROBE_CYC = `STROBE_CYC,
  parameter int RECOVER_CYC = `RECOVER_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire xfer_mode_t i_mode,
  input wire logic i_cmd_valid,
  input wire cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_irq,
  input wire pins_in_t i_pins,
  output pins_out_t o_pins
);
  // Counts are loaded minus one into an 8-bit counter
  if (SETUP_CYC < 1 || STROBE_CYC < 1 || RECOVER_CYC < 1 || STROBE_CYC > 255) begin : g_bad_timing
    $error("ide_channel: timing counts out of range");
  end

  typedef enum logic [2:0] {IDLE, SETUP, STROBE, WAIT_RDY, RECOVER} st_t;
  st_t st_q;
  st_t st_d;
  logic [7:0] cnt_q;
  cmd_t cmd_q;
  logic [15:0] rdata_q;
  logic done_q;
  pins_in_t sync1_q;
  pins_in_t sync2_q;

  ////////////////////////////////////////////////////////////
  // Pins are asynchronous to us: two flops before use
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= i_pins;
      sync2_q <= sync1_q;
    end
  end

  wire logic dma_mode = (i_mode != XFER_PIO);
  // Ultra reuses ready as a strobe, so ready never stretches it
  wire logic ready_ok = (i_mode == XFER_ULTRA) || sync2_q.ready;
  wire logic cnt_zero = (cnt_q == 8'h00);
  wire logic in_strobe = (st_q == STROBE) || (st_q == WAIT_RDY);
  // Strobes start only when DMA is requested in DMA modes
  wire logic go = i_cmd_valid && (!dma_mode || sync2_q.dma_request);
  assign o_cmd_ready = (st_q == IDLE) && (!dma_mode || sync2_q.dma_request);

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      IDLE: if (go) st_d = SETUP;
      SETUP: if (cnt_zero) st_d = STROBE;
      STROBE: if (cnt_zero) st_d = WAIT_RDY;
      WAIT_RDY: if (ready_ok) st_d = RECOVER;
      RECOVER: if (cnt_zero) st_d = IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q <= IDLE;
      cnt_q <= 8'h00;
      cmd_q <= '0;
      rdata_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      done_q <= (st_q == RECOVER) && cnt_zero;
      if (st_q == IDLE && go) begin
        cmd_q <= i_cmd;
        cnt_q <= 8'(SETUP_CYC - 1);
      end else if (st_q == SETUP && cnt_zero) begin
        cnt_q <= 8'(STROBE_CYC - 1);
      end else if (st_q == WAIT_RDY && ready_ok) begin
        cnt_q <= 8'(RECOVER_CYC - 1);
        if (!cmd_q.write) rdata_q <= sync2_q.data_in;
      end else if (!cnt_zero) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  assign o_done = done_q;
  assign o_rdata = rdata_q;
  assign o_irq = sync2_q.interrupt_request;

  always_comb begin
    o_pins.addr = cmd_q.addr;
    o_pins.cs1_n = !((st_q != IDLE) && !cmd_q.cs3);
    o_pins.cs3_n = !((st_q != IDLE) && cmd_q.cs3);
    o_pins.rd_n = !(in_strobe && !cmd_q.write);
    o_pins.wr_n = !(in_strobe && cmd_q.write);
    // Data driven from setup on, before the write strobe falls
    o_pins.data_oe = (st_q != IDLE) && cmd_q.write;
    o_pins.data_out = cmd_q.wdata;
    o_pins.grant_n = !(dma_mode && sync2_q.dma_request);
  end

  chk_write_data_first: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_pins.wr_n |-> o_pins.data_oe && $past(o_pins.data_oe))
    else $error("write strobe without prior data");
  chk_ready_stretch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (st_q == WAIT_RDY && i_mode == XFER_PIO && !sync2_q.ready) |=> in_strobe)
    else $error("command ended while not ready");
  chk_grant_follows: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_mode == XFER_DMA && sync2_q.dma_request) |-> !o_pins.grant_n)
    else $error("dma request not granted");
  chk_strobe_excl: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(!o_pins.rd_n && !o_pins.wr_n) && (o_pins.rd_n || !(o_pins.cs1_n && o_pins.cs3_n)))
    else $error("bad strobe or select");
  chk_select_one: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(!o_pins.cs1_n && !o_pins.cs3_n))
    else $error("both selects active");
endmodule
`default_nettype wire

// ---- verilog/ide_host_params.svh ----
// Timing constants for the two-channel disk interface host
`ifndef IDE_HOST_PARAMS_SVH
`define IDE_HOST_PARAMS_SVH
`define CLK_PERIOD_NS 100
`define SETUP_NS 70
`define STROBE_NS 290
`define RECOVER_NS 240
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYC ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_HOLD_CYC 16
`endif

// ---- verilog/ide_host_pkg.sv ----
// Types shared by the disk interface host files
`default_nettype none
package ide_host_pkg;
  typedef enum logic [1:0] {
    XFER_PIO,
    XFER_DMA,
    XFER_ULTRA
  } xfer_mode_t;

  typedef struct packed {
    logic write;
    logic cs3;
    logic [2:0] addr;
    logic [15:0] wdata;
  } cmd_t;

  typedef struct packed {
    logic [15:0] data_out;
    logic data_oe;
    logic [2:0] addr;
    logic cs1_n;
    logic cs3_n;
    logic rd_n;
    logic wr_n;
    logic grant_n;
  } pins_out_t;

  typedef struct packed {
    logic [15:0] data_in;
    logic ready;
    logic dma_request;
    logic interrupt_request;
  } pins_in_t;
endpackage
`default_nettype wire

// ---- verilog/ide_host_channels.sv ----
// Two-channel disk interface host with shared drive reset
`include "ide_host_params.svh"
`default_nettype none
module ide_host_channels
  import ide_host_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_sys_reset_req,
  input wire xfer_mode_t i_primary_mode,
  input wire logic i_primary_cmd_valid,
  input wire cmd_t i_primary_cmd,
  output logic o_primary_cmd_ready,
  output logic o_primary_done,
  output logic [15:0] o_primary_rdata,
  output logic o_primary_irq,
  input wire pins_in_t i_primary_pins,
  output pins_out_t o_primary_pins,
  input wire xfer_mode_t i_secondary_mode,
  input wire logic i_secondary_cmd_valid,
  input wire cmd_t i_secondary_cmd,
  output logic o_secondary_cmd_ready,
  output logic o_secondary_done,
  output logic [15:0] o_secondary_rdata,
  output logic o_secondary_irq,
  input wire pins_in_t i_secondary_pins,
  output pins_out_t o_secondary_pins,
  output logic o_system_reset_out,
  output logic o_drive_reset_n
);
  logic [4:0] rst_cnt_q;
  logic sysrst_q;

  ////////////////////////////////////////////////////////////
  // Reset pulse stretched so slow drives see it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_cnt_q <= 5'(`RESET_HOLD_CYC);
      sysrst_q <= 1'b1;
    end else begin
      if (i_sys_reset_req) rst_cnt_q <= 5'(`RESET_HOLD_CYC);
      else if (rst_cnt_q != 5'h00) rst_cnt_q <= rst_cnt_q - 5'h01;
      sysrst_q <= i_sys_reset_req || (rst_cnt_q != 5'h00);
    end
  end
  assign o_system_reset_out = sysrst_q;
  assign o_drive_reset_n = !sysrst_q;

  chk_drive_reset_inv: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_drive_reset_n == !o_system_reset_out)
    else $error("drive reset not inverse");
  chk_reset_stretch: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_sys_reset_req |=> o_system_reset_out [*8])
    else $error("system reset too short");

  // Channels share the clock, i_nrst and the system reset that blocks their commands
  ide_channel u_primary (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_mode(i_primary_mode),
    .i_cmd_valid(i_primary_cmd_valid && !sysrst_q),
    .i_cmd(i_primary_cmd),
    .o_cmd_ready(o_primary_cmd_ready),
    .o_done(o_primary_done),
    .o_rdata(o_primary_rdata),
    .o_irq(o_primary_irq),
    .i_pins(i_primary_pins),
    .o_pins(o_primary_pins)
  );
  ide_channel u_secondary (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_mode(i_secondary_mode),
    .i_cmd_valid(i_secondary_cmd_valid && !sysrst_q),
    .i_cmd(i_secondary_cmd),
    .o_cmd_ready(o_secondary_cmd_ready),
    .o_done(o_secondary_done),
    .o_rdata(o_secondary_rdata),
    .o_irq(o_secondary_irq),
    .i_pins(i_secondary_pins),
    .o_pins(o_secondary_pins)
  );
endmodule
`default_nettype wire

// ---- verification/ide_disk_model.sv ----
// Behavioural disk drive hanging on one channel of the host
`default_nettype none
module ide_disk_model
  import ide_host_pkg::*;
(
  input wire logic i_clk,
  input wire pins_out_t i_pins,
  input wire logic [3:0] i_delay,
  input wire logic i_dma_req,
  input wire logic i_irq,
  output pins_in_t o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [8];
  logic [15:0] last = 16'h0000;
  logic [3:0] cnt = 4'h0;
  wire strobe = !(i_pins.rd_n && i_pins.wr_n);
  wire sel = !(i_pins.cs1_n && i_pins.cs3_n);
  wire rd = sel && !i_pins.rd_n;
  always @(posedge i_clk) begin
    cnt <= strobe ? ((cnt == 4'hF) ? cnt : cnt + 4'h1) : 4'h0;
    if (rd) last <= mem[i_pins.addr];
  end
  // Data is taken on the trailing edge, when the host must still drive it
  always @(posedge i_pins.wr_n) if (sel && i_pins.data_oe) mem[i_pins.addr] <= i_pins.data_out;
  // Released bus shows the inverse so a stale value never passes
  assign o_pins.data_in = rd ? mem[i_pins.addr] : ~last;
  assign o_pins.ready = !strobe || cnt >= i_delay;
  assign o_pins.dma_request = i_dma_req;
  assign o_pins.interrupt_request = i_irq;
endmodule
`default_nettype wire

// ---- verification/ide_host_channels_bench.sv ----
// Self-checking bench for the two-channel disk interface host
`default_nettype none
module ide_host_channels_bench;
  import ide_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic sys_req = 1'b0;
  xfer_mode_t mode [2] = '{XFER_PIO, XFER_PIO};
  logic valid [2] = '{1'b0, 1'b0};
  cmd_t cmd [2] = '{'0, '0};
  logic [3:0] delay [2] = '{4'h0, 4'h0};
  logic dreq [2] = '{1'b0, 1'b0};
  logic dirq [2] = '{1'b0, 1'b0};
  logic rdy [2], done [2], irq [2], sys_out, drst_n;
  logic [15:0] rdata [2];
  pins_in_t pin_i [2];
  pins_out_t pin_o [2];
  logic [31:0] seed = 32'hFE8196DC;
  logic [15:0] exp_mem [2][8];
  int errors = 0, n_tests = 0, cyc = 0;
  ide_host_channels DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_sys_reset_req(sys_req),
    .i_primary_mode(mode[0]), .i_primary_cmd_valid(valid[0]), .i_primary_cmd(cmd[0]),
    .o_primary_cmd_ready(rdy[0]), .o_primary_done(done[0]), .o_primary_rdata(rdata[0]),
    .o_primary_irq(irq[0]), .i_primary_pins(pin_i[0]), .o_primary_pins(pin_o[0]),
    .i_secondary_mode(mode[1]), .i_secondary_cmd_valid(valid[1]),
    .i_secondary_cmd(cmd[1]), .o_secondary_cmd_ready(rdy[1]), .o_secondary_done(done[1]),
    .o_secondary_rdata(rdata[1]), .o_secondary_irq(irq[1]), .i_secondary_pins(pin_i[1]),
    .o_secondary_pins(pin_o[1]), .o_system_reset_out(sys_out), .o_drive_reset_n(drst_n));
  for (genvar g = 0; g < 2; g++) begin : g_dev
    ide_disk_model disk (.i_clk(i_clk), .i_pins(pin_o[g]), .i_delay(delay[g]),
      .i_dma_req(dreq[g]), .i_irq(dirq[g]), .o_pins(pin_i[g]));
  end
  initial forever #50 i_clk = ~i_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk1(input logic got, input logic want, input string what);
    n_tests++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %0t %s got %b want %b", $time, what, got, want);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] want, input string what);
    n_tests++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic conclude();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Pins are decoded from registers, so they are settled at the falling edge
  always @(negedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
    for (int c = 0; c < 2; c++) begin
      if (!(pin_o[c].rd_n && pin_o[c].wr_n)) begin
        chk1(pin_o[c].cs3_n, !cmd[c].cs3, "select 3");
        chk1(pin_o[c].cs1_n, cmd[c].cs3, "select 1");
      end
      if (!(pin_o[c].rd_n && pin_o[c].wr_n)) begin
        chk16({13'h0000, pin_o[c].addr}, {13'h0000, cmd[c].addr}, "address");
      end
      if (!pin_o[c].wr_n) begin
        chk1(pin_o[c].data_oe, 1'b1, "write drive");
        chk16(pin_o[c].data_out, cmd[c].wdata, "write data");
      end
    end
  end
  // One transfer, bounded waits for take and completion
  task automatic op(input int c, input logic w, input logic [2:0] a, input logic [15:0] d);
    int k;
    logic [31:0] s;
    s = rnd();
    @(negedge i_clk);
    cmd[c] = '{w, s[3], a, d};
    valid[c] = 1'b1;
    k = 0;
    // Ready is looked at mid-cycle; the take is the rising edge after it
    while (rdy[c] !== 1'b1 && k < 50) begin
      @(negedge i_clk);
      k++;
    end
    @(negedge i_clk);
    valid[c] = 1'b0;
    k = 0;
    // Done stands one cycle, so every falling edge is looked at
    do begin
      @(negedge i_clk);
      k++;
    end while (done[c] !== 1'b1 && k < 100);
    chk1(done[c], 1'b1, "done");
    if (w) exp_mem[c][a] = d;
    else chk16(rdata[c], exp_mem[c][a], "read data");
  endtask
  initial begin
    logic [31:0] s;
    xfer_mode_t m;
    repeat (5) @(negedge i_clk);
    chk1(sys_out, 1'b1, "sys reset");
    chk1(drst_n, 1'b0, "drive reset");
    i_nrst = 1'b1;
    repeat (20) @(negedge i_clk);
    chk1(sys_out, 1'b0, "sys reset");
    chk1(drst_n, 1'b1, "drive reset");
    mode[0] = XFER_DMA;
    valid[0] = 1'b1;
    repeat (4) @(negedge i_clk);
    chk1(rdy[0], 1'b0, "refused");
    chk1(pin_o[0].grant_n, 1'b1, "grant");
    valid[0] = 1'b0;
    for (int i = 0; i < 24; i++) begin
      s = rnd();
      m = xfer_mode_t'(s[1:0] % 2'd3);
      for (int c = 0; c < 2; c++) begin
        mode[c] = m;
        dreq[c] = (m != XFER_PIO);
        dirq[c] = s[c + 12];
        delay[c] = (i == 0) ? 4'hF : s[7:4];
      end
      repeat (4) @(negedge i_clk);
      chk1(pin_o[0].grant_n, m == XFER_PIO, "grant");
      chk1(pin_o[1].grant_n, m == XFER_PIO, "grant");
      chk1(irq[0], s[12], "irq");
      chk1(irq[1], s[13], "irq");
      op(0, 1'b1, s[10:8], s[31:16]);
      op(1, 1'b1, s[10:8], ~s[31:16]);
      op(0, 1'b0, s[10:8], 16'h0000);
      op(1, 1'b0, s[10:8], 16'h0000);
    end
    sys_req = 1'b1;
    repeat (3) @(negedge i_clk);
    chk1(sys_out, 1'b1, "sys reset");
    chk1(drst_n, 1'b0, "drive reset");
    conclude();
  end
endmodule
`default_nettype wire
